// ### logic/sarseq_params.svh
// Constants of the successive-approximation converter sequencer: register indices,
// field positions, reset values and conversion time counts.
// Assumes a system clock equal to the converter clock, so times are counted in clock periods.
// Contract
// R1 - Writing one to the start bit launches conversion of the selected channel.
// R2 - The start bit clears itself once a conversion has been launched.
// R3 - Channel codes 0000 to 0101 select inputs zero to five; others reserved.
// R4 - Input control bit zero enables analog inputs, one disables them.
// R5 - On completion store result, set end flag and pulse interrupt together.
// R6 - Busy sets at start, clears at finish, and clears on stop or slow.
// R7 - Reading the result register clears the end-of-conversion flag.
// R8 - Restart before reading clears end flag but keeps old result until completion.
// R9 - Software must not restart while a conversion is running.
// R10 - Software changes the channel only while busy reads zero.
// R11 - Time codes 000,010..110 give 39,78,156,312,624,1248 clocks; 001,111 reserved.
// R12 - Software avoids time codes forbidden for its operating clock frequency.
// R13 - Ladder bit zero connects ladder only while converting, one connects always.
// R14 - Stop, slow or sleep resets both control registers and blocks their writes.
// R15 - Stop or slow aborts a conversion; no restart without a fresh start.
// R16 - Software writes one to control one bit 5 and zero to bit 6.
// R17 - Software writes zero to control two bit 0 and one to bit 4.
// R18 - Control two bits 7:6 and status bits other than flags read undefined.
// R19 - Entering stop or slow disconnects the analog reference.
// R20 - Software reads status before result, since result read clears the flag.
// R21 - Count selected clock periods from start, then complete; interrupt is one-cycle pulse.
`ifndef SARSEQ_PARAMS_SVH
`define SARSEQ_PARAMS_SVH

`define SARSEQ_IDX_CTRL1 6'h0E
`define SARSEQ_IDX_CTRL2 6'h0F
`define SARSEQ_IDX_RESULT 6'h20
`define SARSEQ_IDX_STATUS 6'h21

`define SARSEQ_CTRL1_RESET 8'h10
`define SARSEQ_CTRL2_RESET 8'h10
`define SARSEQ_RESULT_RESET 8'h00

`define SARSEQ_C1_START 7
`define SARSEQ_C1_FIX6 6
`define SARSEQ_C1_FIX5 5
`define SARSEQ_C1_DISABLE 4
`define SARSEQ_C2_LADDER 5
`define SARSEQ_C2_FIX4 4
`define SARSEQ_C2_TIME_HI 3
`define SARSEQ_C2_TIME_LO 1
`define SARSEQ_C2_FIX0 0
`define SARSEQ_ST_EOC 5
`define SARSEQ_ST_BUSY 4

`define SARSEQ_TIME_000 3'h0
`define SARSEQ_TIME_010 3'h2
`define SARSEQ_TIME_011 3'h3
`define SARSEQ_TIME_100 3'h4
`define SARSEQ_TIME_101 3'h5
`define SARSEQ_TIME_110 3'h6

`define SARSEQ_CYC_000 11'd39
`define SARSEQ_CYC_010 11'd78
`define SARSEQ_CYC_011 11'd156
`define SARSEQ_CYC_100 11'd312
`define SARSEQ_CYC_101 11'd624
`define SARSEQ_CYC_110 11'd1248

`define SARSEQ_TRIAL_CYC 4
`define SARSEQ_NUM_BITS 8

`endif

// ### logic/sarseq_pkg.sv
// Types shared by the converter sequencer files.
// Assumes the constants header is included by every user.
package sarseq_pkg;

	typedef enum logic [1:0] {
		SARSEQ_PWR_NORMAL,
		SARSEQ_PWR_STOP,
		SARSEQ_PWR_SLOW,
		SARSEQ_PWR_SLEEP
	} sarseq_power_t;

	typedef enum logic {
		SARSEQ_IDLE,
		SARSEQ_CONVERT
	} sarseq_state_t;

	typedef struct packed {
		logic [3:0] channel_select;
		logic analog_input_disable;
		logic ladder_connect;
		logic reference_connect;
		logic sample;
		logic [7:0] dac_code;
	} sarseq_analog_t;

endpackage

// ### logic/sarseq_timer.sv
// Conversion timer: counts the selected number of clock periods and paces the bit trials.
// Assumes start and abort come from the same clock domain; start is single-cycle, abort is a level held through stop or slow.
`timescale 1ns/1ps
`include "sarseq_params.svh"
module sarseq_timer #(
	parameter int TRIAL_CYC = `SARSEQ_TRIAL_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic abort_i,
	input wire logic [2:0] time_code_i,
	output logic step_o,
	output logic [2:0] step_bit_o,
	output logic done_o
);
	import sarseq_pkg::*;

	logic running;
	logic [10:0] elapsed;
	logic [10:0] limit;
	logic [7:0] trial_cnt;
	logic [3:0] bits_left;

	// Reserved codes fall back to the shortest time
	always_comb begin
		case (time_code_i) // R11
			`SARSEQ_TIME_000: limit = `SARSEQ_CYC_000;
			`SARSEQ_TIME_010: limit = `SARSEQ_CYC_010;
			`SARSEQ_TIME_011: limit = `SARSEQ_CYC_011;
			`SARSEQ_TIME_100: limit = `SARSEQ_CYC_100;
			`SARSEQ_TIME_101: limit = `SARSEQ_CYC_101;
			`SARSEQ_TIME_110: limit = `SARSEQ_CYC_110;
			default: limit = `SARSEQ_CYC_000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			running <= 1'b0;
			elapsed <= 11'h000;
			done_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (abort_i) begin
				running <= 1'b0;
			end else if (start_i) begin
				running <= 1'b1;
				elapsed <= 11'h001;
			end else if (running) begin
				if (elapsed == limit) begin // R21
					running <= 1'b0;
					done_o <= 1'b1;
				end else begin
					elapsed <= elapsed + 11'h001;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trial_cnt <= 8'h00;
			bits_left <= 4'h0;
			step_o <= 1'b0;
			step_bit_o <= 3'h0;
		end else if (ce_i) begin
			step_o <= 1'b0;
			if (abort_i) begin
				bits_left <= 4'h0;
			end else if (start_i) begin
				bits_left <= 4'(`SARSEQ_NUM_BITS);
				trial_cnt <= 8'h01;
			end else if (bits_left != 4'h0) begin
				if (trial_cnt == 8'(TRIAL_CYC)) begin
					trial_cnt <= 8'h01;
					bits_left <= bits_left - 4'h1;
					step_o <= 1'b1;
					step_bit_o <= 3'(bits_left - 4'h1);
				end else begin
					trial_cnt <= trial_cnt + 8'h01;
				end
			end
		end
	end
endmodule

// ### logic/sarseq_top.sv
// Converter sequencer: control and status registers on classic Wishbone, the bit-trial
// loop that drives the DAC code, and the low-power reaction.
// Assumes an external comparator (asynchronous to clk_i) and a power mode input from the
// system controller on the same clock.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sarseq_params.svh"
module sarseq_top #(
	parameter int TRIAL_CYC = `SARSEQ_TRIAL_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire sarseq_pkg::sarseq_power_t power_mode_i,
	input wire logic comparator_i,
	output sarseq_pkg::sarseq_analog_t analog_o,
	output logic conversion_done_irq_o
);
	import sarseq_pkg::*;

	logic [7:0] conv_control_one;
	logic [7:0] conv_control_two;
	logic [7:0] conv_result;
	logic end_of_conversion_flag;
	logic converter_busy_flag;
	sarseq_state_t state;

	logic low_power;
	logic abort_mode;
	logic bus_req;
	logic bus_write;
	logic bus_read;
	logic [5:0] bus_index;
	logic addr_aligned;
	logic wr_ctrl1;
	logic wr_ctrl2;
	logic rd_result;
	logic launch;
	logic [31:0] next_rdata;

	logic comp_s1;
	logic comp_s2;
	logic comp_s3;
	logic comp_q;

	logic step;
	logic [2:0] step_bit;
	logic timer_done;
	logic [7:0] dac_code;
	logic sample;

	// Any mode but normal resets the control registers; only stop and slow abort a conversion
	assign low_power = (power_mode_i != SARSEQ_PWR_NORMAL);
	assign abort_mode = (power_mode_i == SARSEQ_PWR_STOP) || (power_mode_i == SARSEQ_PWR_SLOW);

	// Bus decode; the answer comes one cycle after the request is seen
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_write = bus_req && wb_we_i;
	assign bus_read = bus_req && !wb_we_i;
	assign bus_index = wb_adr_i[7:2];
	assign addr_aligned = (wb_adr_i[1:0] == 2'h0);
	assign wr_ctrl1 = bus_write && addr_aligned && wb_sel_i[0] && (bus_index == `SARSEQ_IDX_CTRL1);
	assign wr_ctrl2 = bus_write && addr_aligned && wb_sel_i[0] && (bus_index == `SARSEQ_IDX_CTRL2);
	assign rd_result = bus_read && addr_aligned && (bus_index == `SARSEQ_IDX_RESULT);

	// A start request while converting is ignored; the running conversion is not disturbed
	assign launch = conv_control_one[`SARSEQ_C1_START] && (state == SARSEQ_IDLE) && !low_power; // R1

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= bus_req;
		end
	end

	// Read data is captured at the edge that takes the request and stands until the next read
	// Read mux; undefined and unstable bits are returned as zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (addr_aligned) begin
			case (bus_index)
				`SARSEQ_IDX_CTRL1: next_rdata[7:0] = conv_control_one;
				`SARSEQ_IDX_CTRL2: next_rdata[5:0] = conv_control_two[5:0]; // R18
				`SARSEQ_IDX_RESULT: next_rdata[7:0] = conv_result;
				`SARSEQ_IDX_STATUS: begin
					next_rdata[`SARSEQ_ST_EOC] = end_of_conversion_flag; // R18
					next_rdata[`SARSEQ_ST_BUSY] = converter_busy_flag;
				end
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			if (bus_read) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	// Control register one; stored as written, fixed bits 6:5 are software's duty
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_control_one <= `SARSEQ_CTRL1_RESET;
		end else if (ce_i) begin
			if (low_power) begin
				conv_control_one <= `SARSEQ_CTRL1_RESET; // R14
			end else if (wr_ctrl1) begin
				conv_control_one <= wb_dat_i[7:0]; // R16
			end else if (launch) begin
				conv_control_one[`SARSEQ_C1_START] <= 1'b0; // R2
			end else if (state == SARSEQ_CONVERT) begin
				conv_control_one[`SARSEQ_C1_START] <= 1'b0; // R9
			end
		end
	end

	// Control register two; top two bits are not stored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_control_two <= `SARSEQ_CTRL2_RESET;
		end else if (ce_i) begin
			if (low_power) begin
				conv_control_two <= `SARSEQ_CTRL2_RESET; // R14
			end else if (wr_ctrl2) begin
				conv_control_two <= {2'h0, wb_dat_i[5:0]}; // R17
			end
		end
	end

	// Sleep does not stop a running conversion, though it resets its time code and channel; only stop and slow return it to idle
	// Sequencer state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= SARSEQ_IDLE;
		end else if (ce_i) begin
			case (state)
				SARSEQ_IDLE: begin
					if (launch) begin
						state <= SARSEQ_CONVERT;
					end
				end
				SARSEQ_CONVERT: begin
					if (abort_mode) begin
						state <= SARSEQ_IDLE; // R15
					end else if (timer_done) begin
						state <= SARSEQ_IDLE;
					end
				end
				default: state <= SARSEQ_IDLE;
			endcase
		end
	end

	// Busy flag; follows the state machine but drops at once on stop or slow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			converter_busy_flag <= 1'b0;
		end else if (ce_i) begin
			if (abort_mode) begin
				converter_busy_flag <= 1'b0; // R6
			end else if (launch) begin
				converter_busy_flag <= 1'b1; // R6
			end else if (timer_done && state == SARSEQ_CONVERT) begin
				converter_busy_flag <= 1'b0; // R6
			end
		end
	end

	// End-of-conversion flag; completion wins over a result read in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			end_of_conversion_flag <= 1'b0;
		end else if (ce_i) begin
			if (timer_done && state == SARSEQ_CONVERT && !abort_mode) begin
				end_of_conversion_flag <= 1'b1; // R5
			end else if (launch) begin
				end_of_conversion_flag <= 1'b0; // R8
			end else if (rd_result) begin
				end_of_conversion_flag <= 1'b0; // R7
			end
		end
	end

	// Software sees the previous result until a new conversion completes or a stop or slow abort clears it
	// Result register; an abort leaves no trustworthy result, so it is cleared
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_result <= `SARSEQ_RESULT_RESET;
		end else if (ce_i) begin
			if (abort_mode && state == SARSEQ_CONVERT) begin
				conv_result <= `SARSEQ_RESULT_RESET; // R15
			end else if (timer_done && state == SARSEQ_CONVERT) begin
				conv_result <= dac_code; // R5
			end
		end
	end

	// Completion interrupt, one cycle wide
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conversion_done_irq_o <= 1'b0;
		end else if (ce_i) begin
			conversion_done_irq_o <= timer_done && (state == SARSEQ_CONVERT) && !abort_mode; // R21
		end
	end

	// Comparator synchroniser; the level changes once stages two and three agree
	// Only stage two reads stage one, so a metastable first stage never reaches the trials
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			comp_s1 <= 1'b0;
			comp_s2 <= 1'b0;
			comp_s3 <= 1'b0;
			comp_q <= 1'b0;
		end else if (ce_i) begin
			comp_s1 <= comparator_i;
			comp_s2 <= comp_s1;
			comp_s3 <= comp_s2;
			if (comp_s2 == comp_s3) begin
				comp_q <= comp_s3;
			end
		end
	end

	// The timer restarts its count on launch and drops it in the same cycle as an abort
	sarseq_timer #(
		.TRIAL_CYC(TRIAL_CYC)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.start_i(launch),
		.abort_i(abort_mode),
		.time_code_i(conv_control_two[`SARSEQ_C2_TIME_HI:`SARSEQ_C2_TIME_LO]),
		.step_o(step),
		.step_bit_o(step_bit),
		.done_o(timer_done)
	);

	// Bit trials: keep the trial bit when the input is above the DAC, then try the next bit
	// Each bit is set high one trial before its own decision, so the code walks MSB first
	genvar b;
	generate
		for (b = 0; b < `SARSEQ_NUM_BITS; b++) begin : g_trial
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					dac_code[b] <= 1'b0;
				end else if (ce_i) begin
					if (launch) begin
						dac_code[b] <= (b == `SARSEQ_NUM_BITS - 1); // R1
					end else if (step && state == SARSEQ_CONVERT) begin
						if (int'(step_bit) == b) begin
							dac_code[b] <= comp_q;
						end else if (int'(step_bit) == b + 1) begin
							dac_code[b] <= 1'b1;
						end
					end
				end
			end
		end
	endgenerate

	// Sample phase covers the first trial window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample <= 1'b0;
		end else if (ce_i) begin
			if (launch) begin
				sample <= 1'b1;
			end else if (step || abort_mode || state == SARSEQ_IDLE) begin
				sample <= 1'b0;
			end
		end
	end

	// Analog side controls, all registered
	// The reference stays connected except in stop and slow, so no current flows while powered down
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			analog_o <= '0;
		end else if (ce_i) begin
			analog_o.channel_select <= conv_control_one[3:0]; // R3
			analog_o.analog_input_disable <= conv_control_one[`SARSEQ_C1_DISABLE]; // R4
			analog_o.ladder_connect <= !abort_mode && (conv_control_two[`SARSEQ_C2_LADDER]
				|| launch || state == SARSEQ_CONVERT); // R13
			analog_o.reference_connect <= !abort_mode; // R19
			analog_o.sample <= sample;
			analog_o.dac_code <= dac_code;
		end
	end
endmodule

// ### verif/sarseq_top_properties.sv
// Checker for the converter sequencer: bus handshake, read masks, interrupt pulse and low-power reaction.
// Assumes binding to sarseq_top and a single clock with synchronous active-high reset.
`timescale 1ns/1ps
module sarseq_top_properties #(
	parameter int TRIAL_CYC = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire sarseq_pkg::sarseq_power_t power_mode_i,
	input wire logic comparator_i,
	input wire sarseq_pkg::sarseq_analog_t analog_o,
	input wire logic conversion_done_irq_o
);
	import sarseq_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_irq_single: assert property (conversion_done_irq_o |=> !conversion_done_irq_o)
		else $error("irq longer than one cycle");
	a_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_status_spare: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h84 |-> wb_dat_o[7:6] == 2'h0 && wb_dat_o[3:0] == 4'h0)
		else $error("status spare bits set");
	a_ctrl2_top: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h3C |-> wb_dat_o[7:6] == 2'h0)
		else $error("control two top bits set");
	a_ref_off: assert property ((power_mode_i inside {SARSEQ_PWR_STOP, SARSEQ_PWR_SLOW})[*3] |-> !analog_o.reference_connect)
		else $error("reference connected in low power");
	a_ctrl_held: assert property ((power_mode_i != SARSEQ_PWR_NORMAL)[*3] |-> analog_o.channel_select == 4'h0 && analog_o.analog_input_disable)
		else $error("control one not at reset value");
	a_no_irq_stop: assert property ((power_mode_i inside {SARSEQ_PWR_STOP, SARSEQ_PWR_SLOW})[*3] |-> !conversion_done_irq_o)
		else $error("irq during low power");
	c_irq: cover property (conversion_done_irq_o);
	c_stop: cover property ((power_mode_i == SARSEQ_PWR_STOP)[*3]);
	c_status_read: cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h84);
endmodule

bind sarseq_top sarseq_top_properties #(.TRIAL_CYC(TRIAL_CYC)) u_props (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.power_mode_i(power_mode_i),
	.comparator_i(comparator_i),
	.analog_o(analog_o),
	.conversion_done_irq_o(conversion_done_irq_o)
);

// ### verif/sarseq_top_tb_top.sv
// Testbench for the converter sequencer: Wishbone register access, conversions over all time codes,
// restart without reading, and abort by low-power modes.
// Assumes a constant comparator level, so results are all ones or all zeros.
`timescale 1ns/1ps
module sarseq_top_tb_top;
	import sarseq_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic comparator_i = 1'b0;
	logic ce_i = 1'b1;
	logic conversion_done_irq_o;
	sarseq_power_t power_mode_i = SARSEQ_PWR_NORMAL;
	sarseq_analog_t analog_o;
	int mismatches = 0;
	int n_compared = 0;
	int n_irq = 0;
	int k;
	time t0;
	time irq_at;
	logic [7:0] rd;
	logic [7:0] ctl1;
	logic [7:0] prev = 8'h00;
	logic [7:0] res;
	int lim[8] = '{39, 39, 78, 156, 312, 624, 1248, 39};

	sarseq_top #(.TRIAL_CYC(4)) DUT (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.power_mode_i(power_mode_i),
		.comparator_i(comparator_i),
		.analog_o(analog_o),
		.conversion_done_irq_o(conversion_done_irq_o)
	);

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		if (conversion_done_irq_o === 1'b1) begin
			n_irq++;
			irq_at = $time;
		end
	end

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic hang(input string s);
		mismatches++;
		$display("wrong value at %0t: %s timed out", $time, s);
		tally_and_finish();
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string s);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, s, got, exp);
		end
	endtask

	task automatic check_rng(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("wrong value at %0t: completion after %0d cycles, limits %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// One classic cycle; waits for ack, then leaves an idle cycle
	task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) hang("bus");
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rchk(input logic [7:0] adr, input logic [7:0] exp);
		bus(1'b0, adr, 8'h00);
		check8(rd, exp, "register read");
	endtask

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rchk(8'h38, 8'h10);
		rchk(8'h3C, 8'h10);
		rchk(8'h80, 8'h00);
		rchk(8'h84, 8'h00);
		rchk(8'h40, 8'h00);
		// Every time code, channels 0..5, both input and ladder settings
		for (int i = 0; i < 8; i++) begin
			ctl1 = 8'h20 | {3'h0, i[0], 4'(i % 6)};
			comparator_i <= i[0];
			res = i[0] ? 8'hFF : 8'h00;
			bus(1'b1, 8'h3C, {2'b00, i[1], 1'b1, 3'(i), 1'b0});
			bus(1'b1, 8'h38, ctl1);
			check8(8'(analog_o.channel_select), 8'(i % 6), "channel");
			check8(8'(analog_o.analog_input_disable), 8'(i[0]), "input disable");
			check8(8'(analog_o.ladder_connect), 8'(i[1]), "idle ladder");
			k = n_irq;
			bus(1'b1, 8'h38, ctl1 | 8'h80);
			t0 = $time;
			rchk(8'h38, ctl1);
			rchk(8'h84, 8'h10);
			rchk(8'h80, prev);
			check8(8'(analog_o.ladder_connect), 8'h01, "busy ladder");
			// First conversion also shows that a low clock enable freezes the count
			if (i == 0) begin
				ce_i <= 1'b0;
				repeat (20) @(posedge clk_i);
				ce_i <= 1'b1;
			end
			for (int n = 0; n_irq == k; n++) begin
				if (n > 1400) hang("completion");
				@(posedge clk_i);
			end
			check_rng(int'((irq_at - t0) / 10), lim[i] + (i == 0 ? 20 : 0), lim[i] + (i == 0 ? 24 : 4));
			rchk(8'h84, 8'h20);
			if (!i[1]) begin
				rchk(8'h80, res);
				rchk(8'h84, 8'h00);
			end
			prev = res;
		end
		// Abort by stop and by slow, then sleep blocks writes; nothing restarts afterwards
		for (int m = 1; m < 3; m++) begin
			bus(1'b1, 8'h3C, 8'h1C);
			bus(1'b1, 8'h38, 8'hA1);
			power_mode_i <= sarseq_power_t'(m);
			repeat (4) @(posedge clk_i);
			check8(8'(analog_o.reference_connect), 8'h00, "reference");
			rchk(8'h84, 8'h00);
			rchk(8'h80, 8'h00);
			bus(1'b1, 8'h38, 8'h25);
			rchk(8'h38, 8'h10);
			power_mode_i <= SARSEQ_PWR_SLEEP;
			bus(1'b1, 8'h3C, 8'h3E);
			rchk(8'h3C, 8'h10);
			power_mode_i <= SARSEQ_PWR_NORMAL;
			k = n_irq;
			repeat (1300) @(posedge clk_i);
			check8(8'(n_irq - k), 8'h00, "irq after abort");
			rchk(8'h84, 8'h00);
			check8(8'(analog_o.reference_connect), 8'h01, "reference back");
		end
		tally_and_finish();
	end
endmodule
